// ===== usc_map.svh
// Register indices, field positions and reset values of the serial control unit
`ifndef USC_MAP_SVH
`define USC_MAP_SVH

//------------------------------------------------------------
// Register indices (byte address is four times the index)
//------------------------------------------------------------
`define USC_IDX_CSR0    8'h86
`define USC_IDX_UCR0    8'hC4
`define USC_IDX_GCR0    8'hC5
`define USC_IDX_DBUF0   8'hC1
`define USC_IDX_BAUD0   8'hC2
`define USC_IDX_CSR1    8'hF8
`define USC_IDX_UCR1    8'hFB
`define USC_IDX_GCR1    8'hFC
`define USC_IDX_DBUF1   8'hF9
`define USC_IDX_BAUD1   8'hFA
`define USC_IDX_IRQ_ST  8'hE0
`define USC_IDX_IRQ_EN  8'hE1

//------------------------------------------------------------
// Field positions
//------------------------------------------------------------
`define USC_CSR_MODE    7
`define USC_CSR_RE      6
`define USC_CSR_SLAVE   5
`define USC_CSR_FE      4
`define USC_CSR_PERR    3
`define USC_CSR_RXB     2
`define USC_CSR_TXB     1
`define USC_UCR_FLUSH   7
`define USC_UCR_D9      5
`define USC_UCR_BIT9    4
`define USC_UCR_PAR     3
`define USC_UCR_SPB     2
`define USC_UCR_STOP    1
`define USC_UCR_START   0
`define USC_GCR_CPOL    7
`define USC_GCR_CLOCK_PHASE_SEL    6
`define USC_GCR_ORDER   5
`define USC_GCR_EXP     4:0

//------------------------------------------------------------
// Reset values and counts
//------------------------------------------------------------
`define USC_UCR_RST     7'h02
`define USC_DATA_LAST   4'h7
`define USC_SPI_LAST    5'h0F
`define USC_SLV_LAST    4'h8

`endif

// ===== usc_pkg.sv
// Types shared by the serial control unit
package usc_pkg;

	typedef enum logic [2:0] {
		USC_IDLE  = 3'b000,
		USC_START = 3'b001,
		USC_DATA  = 3'b010,
		USC_PAR   = 3'b011,
		USC_STOP1 = 3'b100,
		USC_STOP2 = 3'b101
	} usc_phase_t;

	typedef struct packed {
		logic txd;
		logic sck;
		logic sck_oe;
		logic rx_dma;
		logic tx_dma;
	} usc_pins_t;

	typedef struct packed {
		logic       mode;
		logic       rx_on;
		logic       slave;
		logic       fe;
		logic       perr;
		logic       rx_byte;
		logic       tx_byte;
		logic [6:0] ucr;
		logic [7:0] gcr;
		logic [7:0] baud;
		logic [7:0] rx_data;
		logic [7:0] tx_hold;
		logic       hold_full;
		usc_phase_t tx_ph;
		usc_phase_t rx_ph;
		logic [8:0] tx_sh;
		logic [8:0] rx_sh;
		logic [4:0] tx_cnt;
		logic [3:0] rx_cnt;
		logic [12:0] tx_div;
		logic [12:0] rx_div;
		logic       rxd_m;
		logic       rxd_s;
		logic       sck_m;
		logic       sck_s;
		logic       sck_d;
		logic       ssn_m;
		logic       ssn_s;
		logic       ssn_d;
		logic       rx_flag;
		logic       tx_flag;
		logic       rx_ie;
		logic       tx_ie;
		usc_pins_t  pins;
	} usc_unit_t;

	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
	} usc_bus_t;

	function automatic logic [7:0] usc_rev8(input logic [7:0] d);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = d[7-i];
		end
		return r;
	endfunction : usc_rev8

endpackage : usc_pkg

// ===== usc_ctrl.sv
// Dual serial unit: control/status, abort, interrupt flags and DMA triggers
`timescale 1ns/100ps
`include "usc_map.svh"

module usc_ctrl
	import usc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Avalon-MM slave
	input  wire logic [9:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	// Interrupt
	output logic             irq_o,
	// Serial pins per unit
	input  wire logic [1:0]  rxd_i,
	input  wire logic [1:0]  sck_i,
	input  wire logic [1:0]  ssn_n_i,
	output logic      [1:0]  txd_o,
	output logic      [1:0]  sck_o,
	output logic      [1:0]  sck_oe_o,
	// DMA triggers per unit
	output logic      [1:0]  rx_dma_o,
	output logic      [1:0]  tx_dma_o
);

	//------------------------------------------------------------
	// Bus slave
	//------------------------------------------------------------
	usc_unit_t  u_q [2];
	usc_bus_t   bus_q;
	usc_bus_t   next_bus;
	logic [7:0] idx;
	logic       wr;

	assign idx           = address_i[9:2];
	assign wr            = write_i & bus_q.ack & byteenable_i[0] & (address_i[1:0] == 2'b00);
	assign waitrequest_o = (read_i | write_i) & ~bus_q.ack;
	assign readdata_o    = {24'h00_0000, bus_q.rdata};
	assign irq_o         = |{u_q[1].tx_flag & u_q[1].tx_ie, u_q[1].rx_flag & u_q[1].rx_ie,
	                         u_q[0].tx_flag & u_q[0].tx_ie, u_q[0].rx_flag & u_q[0].rx_ie};

	always_comb begin
		next_bus       = bus_q;
		next_bus.ack   = (read_i | write_i) & ~bus_q.ack;
		next_bus.rdata = '0;
		if (address_i[1:0] == 2'b00) begin
			for (int i = 0; i < 2; i++) begin
				if (idx == (i == 1 ? `USC_IDX_CSR1 : `USC_IDX_CSR0)) begin
					next_bus.rdata = {u_q[i].mode, u_q[i].rx_on, u_q[i].slave, u_q[i].fe, u_q[i].perr,
					                  u_q[i].rx_byte, u_q[i].tx_byte,
					                  (u_q[i].tx_ph != USC_IDLE) | (u_q[i].rx_ph != USC_IDLE)};
				end
				if (idx == (i == 1 ? `USC_IDX_UCR1 : `USC_IDX_UCR0)) begin
					next_bus.rdata = {1'b0, u_q[i].ucr};
				end
				if (idx == (i == 1 ? `USC_IDX_GCR1 : `USC_IDX_GCR0)) begin
					next_bus.rdata = u_q[i].gcr;
				end
				if (idx == (i == 1 ? `USC_IDX_DBUF1 : `USC_IDX_DBUF0)) begin
					next_bus.rdata = u_q[i].rx_data;
				end
				if (idx == (i == 1 ? `USC_IDX_BAUD1 : `USC_IDX_BAUD0)) begin
					next_bus.rdata = u_q[i].baud;
				end
			end
			if (idx == `USC_IDX_IRQ_ST) begin
				next_bus.rdata = {4'h0, u_q[1].tx_flag, u_q[1].rx_flag, u_q[0].tx_flag, u_q[0].rx_flag};
			end
			if (idx == `USC_IDX_IRQ_EN) begin
				next_bus.rdata = {4'h0, u_q[1].tx_ie, u_q[1].rx_ie, u_q[0].tx_ie, u_q[0].rx_ie};
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_q <= '0;
		end else begin
			bus_q <= next_bus;
		end
	end

	//------------------------------------------------------------
	// Serial units
	//------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_unit
			usc_unit_t   u;
			usc_unit_t   n;
			logic [12:0] period;
			logic        tx_tick;
			logic        rx_tick;
			logic        rx_evt;
			logic        tx_evt;
			logic        sck_lead;
			logic        sck_trail;
			logic        ninth;
			logic [7:0]  rx_word;

			assign u         = u_q[g];
			assign period    = {u.gcr[`USC_GCR_EXP], u.baud};
			assign tx_tick   = (u.tx_div == 13'h0000);
			assign rx_tick   = (u.rx_div == 13'h0000);
			assign sck_lead  = (u.sck_s ^ u.gcr[`USC_GCR_CPOL]) & ~(u.sck_d ^ u.gcr[`USC_GCR_CPOL]);
			assign sck_trail = ~(u.sck_s ^ u.gcr[`USC_GCR_CPOL]) & (u.sck_d ^ u.gcr[`USC_GCR_CPOL]);
			assign ninth     = u.ucr[`USC_UCR_PAR] ? (^u.tx_hold ^ u.ucr[`USC_UCR_D9]) : u.ucr[`USC_UCR_D9];
			assign rx_word   = u.ucr[`USC_UCR_BIT9] ? u.rx_sh[7:0] : u.rx_sh[8:1];

			always_comb begin
				n             = u;
				rx_evt        = 1'b0;
				tx_evt        = 1'b0;
				n.pins.rx_dma = 1'b0;
				n.pins.tx_dma = 1'b0;
				n.pins.sck_oe = ~u.mode & ~u.slave;
				n.rxd_m       = rxd_i[g];
				n.rxd_s       = u.rxd_m;
				n.sck_m       = sck_i[g];
				n.sck_s       = u.sck_m;
				n.sck_d       = u.sck_s;
				n.ssn_m       = ssn_n_i[g];
				n.ssn_s       = u.ssn_m;
				n.ssn_d       = u.ssn_s;
				n.tx_div      = tx_tick ? period : u.tx_div - 13'h0001;
				n.rx_div      = rx_tick ? period : u.rx_div - 13'h0001;

				// Register writes; held CSR status bits clear on written zero, IRQ status flags on written one, and a DBUF write also clears tx_byte
				if (wr && idx == (g == 1 ? `USC_IDX_CSR1 : `USC_IDX_CSR0)) begin
					n.mode    = writedata_i[`USC_CSR_MODE];
					n.rx_on   = writedata_i[`USC_CSR_RE];
					n.slave   = writedata_i[`USC_CSR_SLAVE];
					n.fe      = u.fe & writedata_i[`USC_CSR_FE];
					n.perr    = u.perr & writedata_i[`USC_CSR_PERR];
					n.rx_byte = u.rx_byte & writedata_i[`USC_CSR_RXB];
					n.tx_byte = u.tx_byte & writedata_i[`USC_CSR_TXB];
				end
				if (wr && idx == (g == 1 ? `USC_IDX_UCR1 : `USC_IDX_UCR0)) begin
					n.ucr = writedata_i[6:0];
				end
				if (wr && idx == (g == 1 ? `USC_IDX_GCR1 : `USC_IDX_GCR0)) begin
					n.gcr = writedata_i[7:0];
				end
				if (wr && idx == (g == 1 ? `USC_IDX_BAUD1 : `USC_IDX_BAUD0)) begin
					n.baud = writedata_i[7:0];
				end
				if (wr && idx == (g == 1 ? `USC_IDX_DBUF1 : `USC_IDX_DBUF0)) begin
					n.tx_hold   = writedata_i[7:0];
					n.hold_full = 1'b1;
					n.tx_byte   = 1'b0;
				end
				if (wr && idx == `USC_IDX_IRQ_EN) begin
					n.rx_ie = writedata_i[2*g];
					n.tx_ie = writedata_i[2*g+1];
				end
				if (wr && idx == `USC_IDX_IRQ_ST) begin
					n.rx_flag = u.rx_flag & ~writedata_i[2*g];
					n.tx_flag = u.tx_flag & ~writedata_i[2*g+1];
				end

				// Transmit side: asynchronous frames or SPI master byte
				case (u.tx_ph)
					USC_IDLE: begin
						n.tx_div = period;
						n.pins.sck = u.gcr[`USC_GCR_CPOL];
						if (u.mode) begin
							n.pins.txd = ~u.ucr[`USC_UCR_START];
						end
						if (u.hold_full && (u.mode || !u.slave)) begin
							n.tx_sh     = {ninth, u.gcr[`USC_GCR_ORDER] ? usc_rev8(u.tx_hold) : u.tx_hold};
							n.hold_full = 1'b0;
							n.tx_cnt    = '0;
							tx_evt      = 1'b1;
							if (u.mode) begin
								n.pins.txd = u.ucr[`USC_UCR_START];
								n.tx_ph    = USC_START;
							end else begin
								n.pins.txd = u.gcr[`USC_GCR_ORDER] ? u.tx_hold[7] : u.tx_hold[0];
								n.tx_ph    = USC_DATA;
							end
						end
					end
					USC_START: begin
						if (tx_tick) begin
							n.pins.txd = u.tx_sh[0];
							n.tx_ph    = USC_DATA;
						end
					end
					USC_DATA: begin
						if (tx_tick && u.mode) begin
							n.tx_cnt   = u.tx_cnt + 5'h01;
							n.tx_sh    = {1'b0, u.tx_sh[8:1]};
							n.pins.txd = u.tx_sh[1];
							if (u.tx_cnt[3:0] == `USC_DATA_LAST) begin
								n.tx_ph = u.ucr[`USC_UCR_BIT9] ? USC_PAR : USC_STOP1;
								if (!u.ucr[`USC_UCR_BIT9]) begin
									n.pins.txd = u.ucr[`USC_UCR_STOP];
								end
							end
						end else if (tx_tick) begin
							n.pins.sck = ~u.pins.sck;
							n.tx_cnt   = u.tx_cnt + 5'h01;
							if (u.tx_cnt[0] == u.gcr[`USC_GCR_CLOCK_PHASE_SEL]) begin
								n.rx_sh = {u.rxd_s, u.rx_sh[8:1]};
							end
							if (u.tx_cnt[0]) begin
								n.tx_sh    = {1'b0, u.tx_sh[8:1]};
								n.pins.txd = u.tx_sh[1];
							end
							if (u.tx_cnt == `USC_SPI_LAST) begin
								n.tx_ph   = USC_IDLE;
								n.tx_byte = 1'b1;
								n.rx_byte = 1'b1;
								rx_evt    = 1'b1;
								n.rx_data = u.gcr[`USC_GCR_ORDER] ? usc_rev8(n.rx_sh[8:1]) : n.rx_sh[8:1];
							end
						end
					end
					USC_PAR: begin
						if (tx_tick) begin
							n.pins.txd = u.ucr[`USC_UCR_STOP];
							n.tx_ph    = USC_STOP1;
						end
					end
					USC_STOP1: begin
						if (tx_tick) begin
							n.tx_ph = u.ucr[`USC_UCR_SPB] ? USC_STOP2 : USC_IDLE;
							if (!u.ucr[`USC_UCR_SPB]) begin
								n.tx_byte = 1'b1;
							end
						end
					end
					USC_STOP2: begin
						if (tx_tick) begin
							n.tx_ph   = USC_IDLE;
							n.tx_byte = 1'b1;
						end
					end
					default: n.tx_ph = USC_IDLE;
				endcase

				// Receive side: asynchronous receiver or SPI slave
				if (u.mode) begin
					case (u.rx_ph)
						USC_IDLE: begin
							if (u.rx_on && u.rxd_s == u.ucr[`USC_UCR_START]) begin
								n.rx_div = {1'b0, period[12:1]};
								n.rx_ph  = USC_START;
							end
						end
						USC_START: begin
							if (rx_tick) begin
								n.rx_cnt = '0;
								n.rx_ph  = (u.rxd_s == u.ucr[`USC_UCR_START]) ? USC_DATA : USC_IDLE;
							end
						end
						USC_DATA: begin
							if (rx_tick) begin
								n.rx_sh  = {u.rxd_s, u.rx_sh[8:1]};
								n.rx_cnt = u.rx_cnt + 4'h1;
								if (u.rx_cnt == `USC_DATA_LAST) begin
									n.rx_ph = u.ucr[`USC_UCR_BIT9] ? USC_PAR : USC_STOP1;
								end
							end
						end
						USC_PAR: begin
							if (rx_tick) begin
								n.rx_sh = {u.rxd_s, u.rx_sh[8:1]};
								if (u.ucr[`USC_UCR_PAR] && (u.rxd_s != (^u.rx_sh[8:1] ^ u.ucr[`USC_UCR_D9]))) begin
									n.perr = 1'b1;
								end
								n.rx_ph = USC_STOP1;
							end
						end
						USC_STOP1: begin
							if (rx_tick) begin
								n.rx_data = u.gcr[`USC_GCR_ORDER] ? usc_rev8(rx_word) : rx_word;
								n.rx_ph   = (u.ucr[`USC_UCR_SPB] && u.rxd_s == u.ucr[`USC_UCR_STOP]) ? USC_STOP2 : USC_IDLE;
								if (u.rxd_s == u.ucr[`USC_UCR_STOP]) begin
									n.rx_byte = 1'b1;
									rx_evt    = 1'b1;
								end else begin
									n.fe = 1'b1;
								end
							end
						end
						USC_STOP2: begin
							if (rx_tick) begin
								n.rx_ph = USC_IDLE;
								if (u.rxd_s != u.ucr[`USC_UCR_STOP]) begin
									n.fe = 1'b1;
								end
							end
						end
						default: n.rx_ph = USC_IDLE;
					endcase
				end else if (u.slave) begin
					if (u.ssn_d && !u.ssn_s) begin
						n.rx_ph     = USC_DATA;
						n.rx_cnt    = '0;
						n.tx_sh     = {1'b0, u.gcr[`USC_GCR_ORDER] ? usc_rev8(u.tx_hold) : u.tx_hold};
						n.pins.txd  = u.gcr[`USC_GCR_ORDER] ? u.tx_hold[7] : u.tx_hold[0];
						n.hold_full = 1'b0;
						tx_evt      = 1'b1;
					end else if (u.ssn_s) begin
						n.rx_ph = USC_IDLE;
					end else if (u.rx_ph == USC_DATA) begin
						if (u.gcr[`USC_GCR_CLOCK_PHASE_SEL] ? sck_trail : sck_lead) begin
							n.rx_sh  = {u.rxd_s, u.rx_sh[8:1]};
							n.rx_cnt = u.rx_cnt + 4'h1;
							if (u.rx_cnt == `USC_DATA_LAST) begin
								n.rx_byte = 1'b1;
								rx_evt    = 1'b1;
								n.rx_cnt  = '0;
								n.rx_data = u.gcr[`USC_GCR_ORDER] ? usc_rev8(u.rxd_s ? {1'b1, u.rx_sh[8:2]} :
								            {1'b0, u.rx_sh[8:2]}) : {u.rxd_s, u.rx_sh[8:2]};
							end
						end
						if (u.gcr[`USC_GCR_CLOCK_PHASE_SEL] ? sck_lead : sck_trail) begin
							n.tx_sh    = {1'b0, u.tx_sh[8:1]};
							n.pins.txd = u.tx_sh[1];
						end
					end
				end else begin
					n.rx_ph = USC_IDLE;
				end

				// Events: set wins over a same-cycle clear
				if (rx_evt) begin
					n.rx_flag     = 1'b1;
					n.pins.rx_dma = 1'b1;
				end
				if (tx_evt) begin
					n.tx_flag     = 1'b1;
					n.pins.tx_dma = 1'b1;
				end

				// Abort: drop transfer, empty buffers, clear held status
				if (wr && idx == (g == 1 ? `USC_IDX_UCR1 : `USC_IDX_UCR0) && writedata_i[`USC_UCR_FLUSH]) begin
					n.tx_ph     = USC_IDLE;
					n.rx_ph     = USC_IDLE;
					n.hold_full = 1'b0;
					n.tx_hold   = '0;
					n.rx_data   = '0;
					n.tx_sh     = '0;
					n.rx_sh     = '0;
					n.fe        = 1'b0;
					n.perr      = 1'b0;
					n.rx_byte   = 1'b0;
					n.tx_byte   = 1'b0;
					n.pins.txd  = ~writedata_i[`USC_UCR_START];
					n.pins.sck  = u.gcr[`USC_GCR_CPOL];
				end
			end

			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					u_q[g]          <= '0;
					u_q[g].ucr      <= `USC_UCR_RST;
					u_q[g].pins.txd <= 1'b1;
					u_q[g].rxd_m    <= 1'b1;
					u_q[g].rxd_s    <= 1'b1;
					u_q[g].ssn_m    <= 1'b1;
					u_q[g].ssn_s    <= 1'b1;
					u_q[g].ssn_d    <= 1'b1;
				end else begin
					u_q[g] <= n;
				end
			end

			assign txd_o[g]    = u.pins.txd;
			assign sck_o[g]    = u.pins.sck;
			assign sck_oe_o[g] = u.pins.sck_oe;
			assign rx_dma_o[g] = u.pins.rx_dma;
			assign tx_dma_o[g] = u.pins.tx_dma;
		end
	endgenerate

endmodule : usc_ctrl

// ===== usc_peer.sv
// Serial peer that sends asynchronous frames onto a receive line
`timescale 1ns/100ps

module usc_peer #(
	parameter int BIT_CYC = 8
) (
	// Clock
	input  wire logic clk_i,
	// Line toward the unit
	output logic      rxd_o
);
	// Idle line sits opposite the low start level
	initial rxd_o = 1'b1;

	//----------------------------------------------------------
	// Frame: start, data LSB first, even parity, one or two stops
	//----------------------------------------------------------
	task automatic send(input logic [7:0] d, input logic par_bad, input logic two_stop, input logic stop2_bad);
		logic [11:0] f;
		f = {~stop2_bad, 1'b1, ^d ^ par_bad, d, 1'b0};
		for (int i = 0; i < (two_stop ? 12 : 11); i++) begin
			rxd_o <= f[i];
			repeat (BIT_CYC) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask : send
endmodule : usc_peer

// ===== usc_ctrl_chk.sv
// Port checks for the serial control unit
`timescale 1ns/100ps

module usc_chk (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// Register bus
	input wire logic        read_i,
	input wire logic        write_i,
	input wire logic [31:0] readdata_o,
	input wire logic        waitrequest_o,
	// Events
	input wire logic        irq_o,
	input wire logic [1:0]  txd_o,
	input wire logic [1:0]  rx_dma_o,
	input wire logic [1:0]  tx_dma_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	//----------------------------------------------------------
	// Bus answer
	//----------------------------------------------------------
	sequence s_answer;
		waitrequest_o ##1 !waitrequest_o;
	endsequence

	chk_one_wait: assert property ($rose(read_i | write_i) |-> s_answer)
		else $error("bus answer not after one wait state");
	chk_wait_idle: assert property (!(read_i | write_i) |-> !waitrequest_o)
		else $error("waitrequest without request");
	chk_wait_once: assert property (!waitrequest_o && (read_i | write_i) |=> !(read_i | write_i) || waitrequest_o)
		else $error("second request answered without wait");
	chk_rdata_lane: assert property (read_i && !waitrequest_o |-> readdata_o[31:8] == 24'h00_0000)
		else $error("read data upper lanes not zero");

	//----------------------------------------------------------
	// Events
	//----------------------------------------------------------
	chk_rx_pulse: assert property ($rose(rx_dma_o[0]) |=> $fell(rx_dma_o[0]))
		else $error("receive trigger longer than one cycle");
	chk_tx_pulse: assert property (tx_dma_o[1] |=> !tx_dma_o[1])
		else $error("transmit trigger longer than one cycle");
	chk_irq_cause: assert property ($rose(irq_o) |-> (|{rx_dma_o, tx_dma_o}) || $past(write_i && !waitrequest_o))
		else $error("interrupt rose without event or enable write");
	chk_txd_reset: assert property ($rose(rst_n_i) |-> txd_o == 2'b11)
		else $error("transmit line not idle after reset");
endmodule : usc_chk

bind usc_ctrl usc_chk u_chk (
	.clk_i        (clk_i),
	.rst_n_i      (rst_n_i),
	.read_i       (read_i),
	.write_i      (write_i),
	.readdata_o   (readdata_o),
	.waitrequest_o(waitrequest_o),
	.irq_o        (irq_o),
	.txd_o        (txd_o),
	.rx_dma_o     (rx_dma_o),
	.tx_dma_o     (tx_dma_o)
);

// ===== usc_ctrl_test.sv
// Self-checking bench for the serial control unit
`timescale 1ns/100ps
`include "usc_map.svh"

module usc_ctrl_status_irq_test;
	logic        clk_i;
	logic        rst_n_i;
	logic [9:0]  address_i;
	logic        read_i;
	logic        write_i;
	logic [31:0] writedata_i;
	logic [3:0]  byteenable_i;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic        irq_o;
	logic [1:0]  txd_o;
	logic [1:0]  sck_oe_o;
	logic [1:0]  rx_dma_o;
	logic [1:0]  tx_dma_o;
	logic [1:0]  sck_o;
	logic        sck_d;
	logic        peer_rxd;
	logic [7:0]  d;
	int          n_fail;
	int          n_tests;
	int          rx_n;
	int          tx_n;
	int          rx1_n;
	int          tx0_n;
	int          sck_n;

	usc_peer #(.BIT_CYC(8)) peer (.clk_i(clk_i), .rxd_o(peer_rxd));

	// Unit 1 receives its own transmit line
	usc_ctrl dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
		.writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .irq_o(irq_o), .rxd_i({txd_o[1], peer_rxd}), .sck_i(2'b00),
		.ssn_n_i(2'b11), .txd_o(txd_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .rx_dma_o(rx_dma_o), .tx_dma_o(tx_dma_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		rx_n <= rx_n + int'(rx_dma_o[0]);
		tx_n <= tx_n + int'(tx_dma_o[1]);
		rx1_n <= rx1_n + int'(rx_dma_o[1]);
		tx0_n <= tx0_n + int'(tx_dma_o[0]);
		sck_d <= sck_o[1];
		sck_n <= sck_n + int'(sck_o[1] === 1'b1 && sck_d === 1'b0);
	end

	//----------------------------------------------------------
	// Shared tasks
	//----------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic be,
		output logic [7:0] rd);
		@(posedge clk_i);
		address_i    <= {idx, 2'b00};
		write_i      <= wr;
		read_i       <= ~wr;
		writedata_i  <= {24'h00_0000, wd};
		byteenable_i <= {3'b000, be};
		// Sampled at each rising edge; the watchdog bounds a missing answer
		do begin
			@(posedge clk_i);
			rd = readdata_o[7:0];
		end while (waitrequest_o);
		read_i  <= 1'b0;
		write_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [7:0] x;
		bus(1'b1, idx, v, 1'b1, x);
	endtask : wr

	task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		bus(1'b0, idx, 8'h00, 1'b1, x);
		check(what, x, exp);
	endtask : rdc

	task automatic bits(input int n);
		repeat (n * 8) @(posedge clk_i);
	endtask : bits

	//----------------------------------------------------------
	// Scenarios
	//----------------------------------------------------------
	task automatic t_reset();
		rdc("csr0", `USC_IDX_CSR0, 8'h00);
		rdc("ucr0", `USC_IDX_UCR0, 8'h02);
		rdc("unmapped", 8'h00, 8'h00);
		bus(1'b1, `USC_IDX_CSR0, 8'hC0, 1'b0, d);
		rdc("csr0 lane off", `USC_IDX_CSR0, 8'h00);
		check("irq", {7'h00, irq_o}, 8'h00);
		// Bit period of eight clocks on both units
		wr(`USC_IDX_BAUD0, 8'h07);
		wr(`USC_IDX_UCR0, 8'h9A);
		rdc("ucr0 abort", `USC_IDX_UCR0, 8'h1A);
		wr(`USC_IDX_CSR0, 8'hC0);
		wr(`USC_IDX_BAUD1, 8'h07);
		wr(`USC_IDX_CSR1, 8'h00);
		rdc("csr1 spi", `USC_IDX_CSR1, 8'h00);
		check("master oe", {6'h00, sck_oe_o}, 8'h02);
		wr(`USC_IDX_CSR1, 8'h20);
		rdc("csr1 slave", `USC_IDX_CSR1, 8'h20);
		check("slave oe", {6'h00, sck_oe_o}, 8'h00);
		wr(`USC_IDX_CSR1, 8'hC0);
	endtask : t_reset

	task automatic t_rx_ok();
		peer.send(8'hA5, 1'b0, 1'b0, 1'b0);
		bits(2);
		rdc("csr0 rx", `USC_IDX_CSR0, 8'hC4);
		rdc("dbuf0", `USC_IDX_DBUF0, 8'hA5);
		rdc("irq st", `USC_IDX_IRQ_ST, 8'h01);
		check("rx dma", rx_n[7:0], 8'h01);
		check("irq masked", {7'h00, irq_o}, 8'h00);
		wr(`USC_IDX_IRQ_EN, 8'h01);
		@(negedge clk_i);
		check("irq on", {7'h00, irq_o}, 8'h01);
		wr(`USC_IDX_IRQ_ST, 8'h01);
		@(negedge clk_i);
		check("irq clr", {7'h00, irq_o}, 8'h00);
		wr(`USC_IDX_IRQ_EN, 8'h00);
		rdc("csr0 held", `USC_IDX_CSR0, 8'hC4);
	endtask : t_rx_ok

	task automatic t_rx_err();
		wr(`USC_IDX_CSR0, 8'hC0);
		peer.send(8'h5A, 1'b1, 1'b0, 1'b0);
		bits(2);
		rdc("csr0 parity", `USC_IDX_CSR0, 8'hCC);
		wr(`USC_IDX_CSR0, 8'hC0);
		wr(`USC_IDX_UCR0, 8'h1E);
		fork
			peer.send(8'h3C, 1'b0, 1'b1, 1'b1);
			begin
				@(posedge rx_dma_o[0]);
				rdc("csr0 early", `USC_IDX_CSR0, 8'hC5);
			end
		join
		bits(2);
		rdc("csr0 framing", `USC_IDX_CSR0, 8'hD4);
		wr(`USC_IDX_CSR0, 8'h80);
		peer.send(8'h11, 1'b0, 1'b0, 1'b0);
		bits(2);
		rdc("csr0 rx off", `USC_IDX_CSR0, 8'h80);
		check("rx dma off", rx_n[7:0], 8'h03);
		wr(`USC_IDX_IRQ_ST, 8'h0F);
	endtask : t_rx_err

	task automatic t_tx();
		wr(`USC_IDX_DBUF1, 8'h3C);
		rdc("csr1 busy", `USC_IDX_CSR1, 8'hC1);
		bits(13);
		rdc("csr1 done", `USC_IDX_CSR1, 8'hC6);
		rdc("dbuf1", `USC_IDX_DBUF1, 8'h3C);
		rdc("irq st tx", `USC_IDX_IRQ_ST, 8'h0C);
		check("tx dma", tx_n[7:0], 8'h01);
		wr(`USC_IDX_CSR1, 8'hC0);
		// Abort mid-frame, then wait one bit before touching the unit
		wr(`USC_IDX_DBUF1, 8'hFF);
		bits(3);
		wr(`USC_IDX_UCR1, 8'h82);
		bits(1);
		rdc("csr1 abort", `USC_IDX_CSR1, 8'hC0);
		rdc("ucr1 abort", `USC_IDX_UCR1, 8'h02);
		check("txd abort", {7'h00, txd_o[1]}, 8'h01);
		bits(12);
		rdc("csr1 stays", `USC_IDX_CSR1, 8'hC0);
	endtask : t_tx

	task automatic t_spi();
		// Unit 0 sends one asynchronous frame while unit 1 runs an SPI master byte
		wr(`USC_IDX_DBUF0, 8'h55);
		repeat (2) @(negedge clk_i);
		check("txd0 start", {7'h00, txd_o[0]}, 8'h00);
		wr(`USC_IDX_GCR1, 8'h00);
		wr(`USC_IDX_CSR1, 8'h00);
		wr(`USC_IDX_DBUF1, 8'hA5);
		bits(18);
		rdc("csr1 spi done", `USC_IDX_CSR1, 8'h06);
		rdc("dbuf1 spi", `USC_IDX_DBUF1, 8'hA5);
		rdc("csr0 tx done", `USC_IDX_CSR0, 8'h82);
		rdc("irq st all", `USC_IDX_IRQ_ST, 8'h0E);
		check("sck edges", sck_n[7:0], 8'h08);
		check("sck idle", {6'h00, sck_o}, 8'h00);
		check("rx dma 1", rx1_n[7:0], 8'h02);
		check("tx dma 0", tx0_n[7:0], 8'h01);
		check("tx dma 1", tx_n[7:0], 8'h03);
		wr(`USC_IDX_IRQ_EN, 8'h02);
		@(negedge clk_i);
		check("irq tx", {7'h00, irq_o}, 8'h01);
		wr(`USC_IDX_IRQ_EN, 8'h00);
	endtask : t_spi

	//----------------------------------------------------------
	// Run control
	//----------------------------------------------------------
	task automatic complete_run();
		if (n_fail == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end

	initial begin
		rst_n_i = 1'b0;
		address_i = '0;
		read_i = 1'b0;
		write_i = 1'b0;
		writedata_i = '0;
		byteenable_i = '0;
		n_fail = 0;
		n_tests = 0;
		rx_n = 0;
		tx_n = 0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_rx_ok();
		t_rx_err();
		t_tx();
		t_spi();
		complete_run();
	end
endmodule : usc_ctrl_status_irq_test
